// *** rtl/ebrf_defines.svh ***
`ifndef EBRF_DEFINES_SVH
`define EBRF_DEFINES_SVH

// payload and check widths of one stored word
`define EBRF_DATA_W 64
`define EBRF_CHK_W 8
`define EBRF_CW_W 72
// half of a payload word, the narrow read width
`define EBRF_HALF_W 32
// address bits for the full 36 kbit array (512 x 72)
`define EBRF_ADDR_W 9
// hamming position bits (positions 1..71)
`define EBRF_SYN_W 7
// reset level of the empty and almost-empty flags
`define EBRF_EMPTY_RST 1'b1

`endif

// *** rtl/ebrf_pkg.sv ***
package ebrf_pkg;

   // static configuration straps, change only while idle or in reset
   typedef struct packed {
      logic half;      // 18 kbit capacity instead of 36 kbit
      logic ecc_en;    // store and check hamming bits
      logic out_reg;   // extra output pipeline stage
      logic rd_narrow; // read port 32 bits wide
      logic casc_in;   // write side fed by an upstream block
      logic casc_out;  // read side drains into a downstream block
   } ebrf_cfg_type;

   // handshake flags
   typedef struct packed {
      logic full;
      logic empty;
      logic afull;
      logic aempty;
   } ebrf_flags_type;

   // one read word with its error indications
   typedef struct packed {
      logic [63:0] data;
      logic sbe;
      logic dbe;
   } ebrf_rword_type;

endpackage

// *** rtl/ebrf_ecc_codec.sv ***
`timescale 1ns/1ps
`include "ebrf_defines.svh"

// combinational sec-ded hamming encoder and decoder for 64-bit words
module ebrf_ecc_codec (
   input wire logic [`EBRF_DATA_W-1:0] i_enc_data,
   output logic [`EBRF_CHK_W-1:0] o_enc_check,
   input wire logic [`EBRF_DATA_W-1:0] i_dec_data,
   input wire logic [`EBRF_CHK_W-1:0] i_dec_check,
   output logic [`EBRF_DATA_W-1:0] o_dec_data,
   output logic o_dec_sbe,
   output logic o_dec_dbe
);
   import ebrf_pkg::*;

   // data bits go to every position that is not a power of two
   function automatic logic [`EBRF_CW_W-1:0] spread(input logic [`EBRF_DATA_W-1:0] d);
      logic [`EBRF_CW_W-1:0] cw;
      int k;
      cw = '0;
      k = 0;
      for (int p = 1; p < `EBRF_CW_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            cw[p] = d[k];
            k++;
         end
      end
      return cw;
   endfunction

   // inverse of spread
   function automatic logic [`EBRF_DATA_W-1:0] gather(input logic [`EBRF_CW_W-1:0] cw);
      logic [`EBRF_DATA_W-1:0] d;
      int k;
      d = '0;
      k = 0;
      for (int p = 1; p < `EBRF_CW_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            d[k] = cw[p];
            k++;
         end
      end
      return d;
   endfunction

   // xor of the positions of all set bits
   function automatic logic [`EBRF_SYN_W-1:0] syndrome(input logic [`EBRF_CW_W-1:0] cw);
      logic [`EBRF_SYN_W-1:0] s;
      s = '0;
      for (int p = 1; p < `EBRF_CW_W; p++) begin
         if (cw[p]) begin
            s = s ^ `EBRF_SYN_W'(p);
         end
      end
      return s;
   endfunction

   // encoder: seven position parities plus one overall parity
   always_comb begin
      logic [`EBRF_CW_W-1:0] cw;
      logic [`EBRF_SYN_W-1:0] s;
      cw = spread(i_enc_data);
      s = syndrome(cw);
      for (int i = 0; i < `EBRF_SYN_W; i++) begin
         cw[1 << i] = s[i];
      end
      o_enc_check = {^cw[`EBRF_CW_W-1:1], s}; // R1
   end

   // decoder: a syndrome below 72 with odd overall parity is one flipped bit
   always_comb begin
      logic [`EBRF_CW_W-1:0] cw;
      logic [`EBRF_SYN_W-1:0] s;
      logic par;
      cw = spread(i_dec_data);
      s = '0;
      par = 1'b0;
      for (int i = 0; i < `EBRF_SYN_W; i++) begin
         cw[1 << i] = i_dec_check[i];
      end
      cw[0] = i_dec_check[`EBRF_CHK_W-1];
      s = syndrome(cw);
      par = ^cw;
      o_dec_sbe = 1'b0;
      o_dec_dbe = 1'b0;
      if (par) begin
         // a syndrome beyond the last position cannot be one error
         if (s < `EBRF_SYN_W'(`EBRF_CW_W)) begin
            o_dec_sbe = 1'b1; // R2
            cw[s] = ~cw[s]; // R2
         end else begin
            o_dec_dbe = 1'b1;
         end
      end else if (s != '0) begin
         o_dec_dbe = 1'b1; // R2
      end
      o_dec_data = gather(cw);
   end

endmodule // ebrf_ecc_codec

// *** rtl/ebrf_fifo.sv ***
// Summary of operation
// R1: encode eight hamming bits per stored word
// R2: correct single errors, flag double errors
// R3: codec also usable for external memory
// R4: capacity selectable as 36 or 18 kbit
// R5: flags stay correct whatever the clocking; the block has a single clock, i_ref_clk, for both sides
// R6: pointers advance on accepted accesses only
// R7: full, empty, almost-full, almost-empty flags
// R8: threshold flags follow separate programmable levels
// R9: read width may differ, data repacked
// R10: cascade path chains blocks for depth
// R11: optional output register adds one cycle
// R12: writes when full, reads when empty ignored
// R13: error flags travel with their read word
`timescale 1ns/1ps
`include "ebrf_defines.svh"

module ebrf_fifo #(
   parameter int ADDR_W = `EBRF_ADDR_W
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire ebrf_pkg::ebrf_cfg_type i_cfg,
   input wire logic [ADDR_W:0] i_afull_lvl,
   input wire logic [ADDR_W:0] i_aempty_lvl,
   input wire logic i_wr_en,
   input wire logic [`EBRF_DATA_W-1:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic i_casc_wr,
   input wire logic [`EBRF_DATA_W-1:0] i_casc_data,
   input wire logic i_casc_full,
   input wire logic [`EBRF_DATA_W-1:0] i_ext_enc_data,
   input wire logic [`EBRF_DATA_W-1:0] i_ext_dec_data,
   input wire logic [`EBRF_CHK_W-1:0] i_ext_dec_check,
   output ebrf_pkg::ebrf_flags_type o_flags,
   output ebrf_pkg::ebrf_rword_type o_rd_word,
   output logic o_rd_valid,
   output logic o_wr_ovf,
   output logic o_rd_unf,
   output logic o_casc_wr,
   output logic [`EBRF_DATA_W-1:0] o_casc_data,
   output logic [`EBRF_CHK_W-1:0] o_ext_enc_check,
   output ebrf_pkg::ebrf_rword_type o_ext_dec_word
);
   import ebrf_pkg::*;

   localparam int DEPTH = 1 << ADDR_W; // entries of the full array
   localparam int CW = ADDR_W + 1;     // occupancy counter width

   // complete module state, registered as one
   typedef struct packed {
      logic [DEPTH-1:0][`EBRF_CW_W-1:0] mem; // storage, payload plus check bits
      logic [ADDR_W-1:0] wptr;               // next location to write
      logic [ADDR_W-1:0] rptr;               // next location to read
      logic [CW-1:0] count;                  // occupancy in 64-bit words
      logic hi_next;                         // narrow read: upper half is next
      ebrf_rword_type s1;                    // first read stage
      logic s1_v;
      ebrf_rword_type rd;                    // read port output
      logic rd_v;
      ebrf_flags_type flags;
      logic wr_ovf;
      logic rd_unf;
      logic casc_wr;
      logic [`EBRF_DATA_W-1:0] casc_data;
      logic [`EBRF_CHK_W-1:0] ext_chk;
      ebrf_rword_type ext_dec;
   } ebrf_state_type;

   ebrf_state_type q; // registered state
   ebrf_state_type d; // next state

   logic [CW-1:0] depth_eff;            // live capacity for the chosen size
   logic wr_req;                        // write request from the selected source
   logic [`EBRF_DATA_W-1:0] wr_word;    // write data from the selected source
   logic rd_req;                        // read request from user or cascade
   logic wr_ok;                         // accepted write
   logic rd_ok;                         // accepted read beat
   logic pop;                           // read beat that frees a location
   logic [`EBRF_CHK_W-1:0] enc_chk;     // check bits of the incoming word
   logic [`EBRF_CHK_W-1:0] ext_chk;     // stand-alone encoder result
   logic [`EBRF_DATA_W-1:0] dec_data;   // corrected word at the read pointer
   logic dec_sbe;
   logic dec_dbe;
   // decoder outputs land on plain nets first, one driver each, then are packed
   logic [`EBRF_DATA_W-1:0] ext_dec_data; // stand-alone corrected word
   logic ext_dec_sbe;                   // stand-alone single error seen
   logic ext_dec_dbe;                   // stand-alone double error seen
   ebrf_rword_type ext_word;            // stand-alone decoder result
   ebrf_rword_type fresh;               // read word after ecc and repacking

   // wrap a pointer at the live capacity, shared by both pointers
   function automatic logic [ADDR_W-1:0] ptr_inc(input logic [ADDR_W-1:0] p,
                                                 input logic [CW-1:0] lim);
      logic [CW-1:0] nxt;
      nxt = CW'(p) + CW'(1);
      return (nxt == lim) ? '0 : nxt[ADDR_W-1:0];
   endfunction

   // codec on the internal path: encode writes, decode the word at rptr
   ebrf_ecc_codec u_int_codec (
      .i_enc_data (wr_word),
      .o_enc_check (enc_chk),
      .i_dec_data (q.mem[q.rptr][`EBRF_DATA_W-1:0]),
      .i_dec_check (q.mem[q.rptr][`EBRF_CW_W-1:`EBRF_DATA_W]),
      .o_dec_data (dec_data),
      .o_dec_sbe (dec_sbe),
      .o_dec_dbe (dec_dbe)
   );

   // second codec exposed on ports for external 72-bit memories
   ebrf_ecc_codec u_ext_codec (
      .i_enc_data (i_ext_enc_data),
      .o_enc_check (ext_chk),
      .i_dec_data (i_ext_dec_data),
      .i_dec_check (i_ext_dec_check),
      .o_dec_data (ext_dec_data),
      .o_dec_sbe (ext_dec_sbe),
      .o_dec_dbe (ext_dec_dbe)
   );

   // request steering, acceptance and repacking
   always_comb begin
      // half capacity uses the lower half of the array only
      depth_eff = i_cfg.half ? CW'(DEPTH / 2) : CW'(DEPTH); // R4
      // cascade input replaces the user write port
      wr_req = i_cfg.casc_in ? i_casc_wr : i_wr_en; // R10
      wr_word = i_cfg.casc_in ? i_casc_data : i_wr_data; // R10
      // cascade output drains on its own while downstream has room
      rd_req = i_cfg.casc_out ? ~i_casc_full : i_rd_en; // R10
      wr_ok = wr_req & ~q.flags.full; // R12
      rd_ok = rd_req & ~q.flags.empty; // R12
      // narrow reads free a location only after the upper half
      pop = rd_ok & (~i_cfg.rd_narrow | i_cfg.casc_out | q.hi_next); // R9
      // ecc off passes raw data and never raises error flags
      fresh.data = i_cfg.ecc_en ? dec_data : q.mem[q.rptr][`EBRF_DATA_W-1:0];
      fresh.sbe = i_cfg.ecc_en & dec_sbe; // R13
      fresh.dbe = i_cfg.ecc_en & dec_dbe; // R13
      if (i_cfg.rd_narrow & ~i_cfg.casc_out) begin
         // lower half first, zero-extended
         fresh.data = q.hi_next ? {`EBRF_HALF_W'(0), fresh.data[`EBRF_DATA_W-1:`EBRF_HALF_W]}
                                : {`EBRF_HALF_W'(0), fresh.data[`EBRF_HALF_W-1:0]}; // R9
      end
      // stand-alone decoder result gathered into one word
      ext_word = '{data: ext_dec_data, sbe: ext_dec_sbe, dbe: ext_dec_dbe}; // R3
   end

   // next-state logic
   always_comb begin
      d = q;
      // write stores payload and its check bits in one location
      if (wr_ok) begin
         d.mem[q.wptr] = {i_cfg.ecc_en ? enc_chk : `EBRF_CHK_W'(0), wr_word}; // R1
         d.wptr = ptr_inc(q.wptr, depth_eff); // R6
      end
      if (pop) begin
         d.rptr = ptr_inc(q.rptr, depth_eff); // R6
      end
      // an idle empty fifo rewinds both pointers, so a capacity change
      // never leaves a pointer above the live half of the array
      if (q.flags.empty & ~wr_ok) begin
         d.wptr = '0; // R4
         d.rptr = '0; // R4
      end
      // half toggles per narrow beat, cleared when a location frees
      if (pop) begin
         d.hi_next = 1'b0;
      end else if (rd_ok) begin
         d.hi_next = 1'b1; // R9
      end
      d.count = q.count + CW'(wr_ok) - CW'(pop); // R6
      // flags from the next occupancy so they stand with the pointers
      d.flags.full = (d.count >= depth_eff); // R7
      d.flags.empty = (d.count == '0); // R7
      d.flags.afull = (d.count >= i_afull_lvl); // R8
      d.flags.aempty = (d.count <= i_aempty_lvl); // R8
      // refused accesses are reported for one cycle
      d.wr_ovf = wr_req & q.flags.full; // R12
      d.rd_unf = rd_req & q.flags.empty; // R12
      // first stage always loads, the port picks it or the fresh word
      d.s1 = fresh;
      d.s1_v = rd_ok & ~i_cfg.casc_out;
      if (i_cfg.out_reg) begin
         d.rd = q.s1; // R11
         d.rd_v = q.s1_v; // R11
      end else begin
         d.rd = fresh; // R13
         d.rd_v = rd_ok & ~i_cfg.casc_out;
      end
      // cascade output carries the corrected full word downstream
      d.casc_wr = rd_ok & i_cfg.casc_out; // R10
      d.casc_data = fresh.data; // R10
      // stand-alone codec results registered for one cycle latency
      d.ext_chk = ext_chk; // R3
      d.ext_dec = ext_word; // R3
   end

   // state register; only constants under reset
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
         q.flags.empty <= `EBRF_EMPTY_RST;
         q.flags.aempty <= `EBRF_EMPTY_RST;
      end else begin
         q <= d;
      end
   end

   // all outputs straight from the state register
   // one clock only: flags and pointers share a domain, so no crossing is needed
   assign o_flags = q.flags; // R5
   assign o_rd_word = q.rd;
   assign o_rd_valid = q.rd_v;
   assign o_wr_ovf = q.wr_ovf;
   assign o_rd_unf = q.rd_unf;
   assign o_casc_wr = q.casc_wr;
   assign o_casc_data = q.casc_data;
   assign o_ext_enc_check = q.ext_chk;
   assign o_ext_dec_word = q.ext_dec;

endmodule // ebrf_fifo

// *** test/ebrf_fifo_properties.sv ***
`timescale 1ns/1ps
`include "ebrf_defines.svh"

// port-level checker: read latency, refusals and flag relations
module ebrf_fifo_props #(
   parameter int ADDR_W = 9
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire ebrf_pkg::ebrf_cfg_type i_cfg,
   input wire logic [ADDR_W:0] i_afull_lvl,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [`EBRF_DATA_W-1:0] i_ext_enc_data,
   input wire ebrf_pkg::ebrf_flags_type o_flags,
   input wire logic o_rd_valid,
   input wire logic o_wr_ovf,
   input wire logic o_rd_unf,
   input wire logic [`EBRF_CHK_W-1:0] o_ext_enc_check
);
   import ebrf_pkg::*;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   // a user read that the block must take
   wire rd_ok = i_rd_en && !o_flags.empty && !i_cfg.casc_out;

   AST_RD_ONE: assert property (rd_ok && !i_cfg.out_reg |=> o_rd_valid)
      else $error("read beat late without output stage");
   AST_RD_TWO: assert property (rd_ok && i_cfg.out_reg |-> ##2 o_rd_valid)
      else $error("read beat late with output stage");
   AST_NO_SPUR: assert property (o_rd_valid && !i_cfg.out_reg |-> $past(rd_ok))
      else $error("read beat without a taken read");
   AST_UNF: assert property (i_rd_en && o_flags.empty && !i_cfg.casc_out |=> o_rd_unf)
      else $error("read while empty not reported");
   AST_OVF: assert property (i_wr_en && o_flags.full && !i_cfg.casc_in |=> o_wr_ovf)
      else $error("write while full not reported");
   AST_FILL: assert property (i_wr_en && !o_flags.full && !i_cfg.casc_in |=> !o_flags.empty)
      else $error("empty stays after a taken write");
   AST_EXCL: assert property (!(o_flags.full && o_flags.empty))
      else $error("full and empty together");
   AST_AFULL: assert property (o_flags.full && i_afull_lvl <= 256 |-> o_flags.afull)
      else $error("almost-full low while full");
   AST_ENC0: assert property (i_ext_enc_data == '0 |=> o_ext_enc_check == 8'h00)
      else $error("zero word gives nonzero check bits");

   cover property (o_wr_ovf);
   cover property (o_rd_unf);
   cover property (o_rd_valid && i_cfg.rd_narrow);
endmodule // ebrf_fifo_props

bind ebrf_fifo ebrf_fifo_props #(.ADDR_W(ADDR_W)) u_props (
   .i_ref_clk(i_ref_clk),
   .i_rst_n(i_rst_n),
   .i_cfg(i_cfg),
   .i_afull_lvl(i_afull_lvl),
   .i_wr_en(i_wr_en),
   .i_rd_en(i_rd_en),
   .i_ext_enc_data(i_ext_enc_data),
   .o_flags(o_flags),
   .o_rd_valid(o_rd_valid),
   .o_wr_ovf(o_wr_ovf),
   .o_rd_unf(o_rd_unf),
   .o_ext_enc_check(o_ext_enc_check)
);

// *** test/ebrf_user_model.sv ***
`timescale 1ns/1ps

// user logic on the fifo ports; holds back refused accesses unless told to abuse
module ebrf_user_model (
   input wire logic i_ref_clk,
   input wire ebrf_pkg::ebrf_flags_type i_flags,
   output logic o_wr_en,
   output logic [63:0] o_wr_data,
   output logic o_rd_en
);
   import ebrf_pkg::*;
   initial begin
      o_wr_en = 1'b0;
      o_wr_data = 64'h0;
      o_rd_en = 1'b0;
   end
   // one cycle of requests; aw and ar tell which ones the block takes
   task automatic step(input logic w, input logic [63:0] d, input logic r, input logic ab,
                       output logic aw, output logic ar);
      aw = w && !i_flags.full;
      ar = r && !i_flags.empty;
      o_wr_en = w && (ab || !i_flags.full);
      o_rd_en = r && (ab || !i_flags.empty);
      // idle data bus keeps moving so a stale word is never mistaken for data
      o_wr_data = o_wr_en ? d : ~o_wr_data;
      @(posedge i_ref_clk);
      #1;
   endtask
endmodule // ebrf_user_model

// *** test/test_ecc_block_ram_fifo.sv ***
`timescale 1ns/1ps
`include "ebrf_defines.svh"

module test_ecc_block_ram_fifo;
   import ebrf_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   ebrf_cfg_type cfg = '0;
   logic [9:0] afull_lvl = 10'h3ff; // unreachable until a test sets it
   logic [9:0] aempty_lvl = 10'h0;
   logic [63:0] enc_d = 64'h0;
   logic [63:0] dec_d = 64'h0;
   logic [7:0] dec_c = 8'h0;
   logic [7:0] enc_c;
   logic casc_wr = 1'b0; // upstream strobe into the cascade input
   logic [63:0] casc_data = 64'h0;
   logic casc_full = 1'b0; // downstream stall
   logic casc_strobe; // cascade output strobe
   logic [63:0] casc_word; // cascade output word
   logic wr_en;
   logic rd_en;
   logic rd_valid;
   logic [63:0] wr_data;
   ebrf_flags_type flags;
   ebrf_rword_type rword;
   ebrf_rword_type xword;
   logic [63:0] wq[$]; // words written, oldest first
   logic [65:0] bq[$]; // beats expected at the read port
   logic hi = 1'b0; // next narrow beat is the high half
   int seed = 66906;
   int n_mismatch = 0;
   int compares = 0;
   int count = 0;
   int cap = 512;
   int cyc = 0;

   always #5 ref_clk = ~ref_clk;

   ebrf_fifo dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_cfg(cfg), .i_afull_lvl(afull_lvl),
      .i_aempty_lvl(aempty_lvl), .i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en),
      .i_casc_wr(casc_wr), .i_casc_data(casc_data), .i_casc_full(casc_full),
      .i_ext_enc_data(enc_d),
      .i_ext_dec_data(dec_d), .i_ext_dec_check(dec_c), .o_flags(flags), .o_rd_word(rword),
      .o_rd_valid(rd_valid), .o_wr_ovf(), .o_rd_unf(), .o_casc_wr(casc_strobe),
      .o_casc_data(casc_word),
      .o_ext_enc_check(enc_c), .o_ext_dec_word(xword));
   ebrf_user_model u_user (.i_ref_clk(ref_clk), .i_flags(flags), .o_wr_en(wr_en),
      .o_wr_data(wr_data), .o_rd_en(rd_en));

   task automatic cmp_word(input logic [65:0] e, input logic [65:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic cmp_flags(input ebrf_flags_type e, input ebrf_flags_type g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // flags expected from the occupancy model
   function automatic ebrf_flags_type exp_flags();
      return '{full: count >= cap, empty: count == 0, afull: count >= afull_lvl,
               aempty: count <= aempty_lvl};
   endfunction

   // one cycle of traffic, then the model follows what was taken
   task automatic step(input logic w, input logic [63:0] d, input logic r, input logic ab);
      logic aw;
      logic ar;
      u_user.step(w, d, r, ab, aw, ar);
      if (aw) wq.push_back(d);
      if (ar) begin
         bq.push_back(cfg.rd_narrow ? {32'h0, (hi ? wq[0][63:32] : wq[0][31:0]), 2'b00}
                                    : {wq[0], 2'b00});
         // narrow reads free the slot only after the high half
         if (!cfg.rd_narrow || hi) begin
            void'(wq.pop_front());
            count--;
         end
         hi = cfg.rd_narrow && !hi;
      end
      count += int'(aw);
      cmp_flags(exp_flags(), flags);
   endtask

   // read beats in write order, error flags clear for clean words;
   // looked at mid-cycle, where the beat stands settled
   always @(negedge ref_clk) begin
      if (rd_valid) cmp_word(bq.size() > 0 ? bq.pop_front() : {66{1'bx}}, rword);
   end
   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // stand-alone codec: clean, single-flip and double-flip words
   task automatic codec_test();
      int i;
      int k;
      int m;
      logic [63:0] d;
      for (i = 0; i < 42; i++) begin
         m = i % 3;
         d = (i == 0) ? 64'h0 : {$random(seed), $random(seed)};
         enc_d = d;
         @(posedge ref_clk);
         #1;
         k = {$random(seed)} % 64;
         dec_d = d ^ (m > 0 ? 64'h1 << k : 64'h0) ^ (m == 2 ? 64'h1 << ((k + 1) % 64) : 64'h0);
         dec_c = enc_c;
         @(posedge ref_clk);
         #1;
         cmp_word(m == 2 ? {dec_d, 2'b01} : {d, m == 1, 1'b0}, xword);
      end
      $display("test codec done");
   endtask

   // reset in mid-run: held words are dropped and every flag returns to its idle level
   task automatic reset_test();
      int i;
      for (i = 0; i < 5; i++) step(1'b1, {$random(seed), $random(seed)}, 1'b0, 1'b0);
      rst_n = 1'b0;
      #1;
      cmp_flags(4'b0101, flags);
      cmp_word(66'h0, rword);
      wq.delete();
      count = 0;
      hi = 1'b0;
      @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      step(1'b0, 64'h0, 1'b0, 1'b0);
      $display("test mid-run reset done");
   endtask

   // both cascade ports at once, ecc off: words enter upstream and leave downstream
   task automatic casc_test();
      int i;
      logic aw;
      logic ar;
      cfg = '{half: 1'b0, ecc_en: 1'b0, out_reg: 1'b1, rd_narrow: 1'b1, casc_in: 1'b1,
              casc_out: 1'b1};
      cap = 512;
      for (i = 0; i < 700; i++) begin
         casc_wr = i < 400 && (i < 40 || 1'($random(seed)));
         casc_data = {$random(seed), $random(seed)};
         casc_full = i < 400 && (i < 40 || 1'($random(seed)));
         aw = casc_wr && !flags.full;
         ar = !casc_full && !flags.empty;
         @(posedge ref_clk);
         #1;
         cmp_word(66'(ar), 66'(casc_strobe));
         if (ar) cmp_word({2'b00, wq.pop_front()}, {2'b00, casc_word});
         if (aw) wq.push_back(casc_data);
         count += int'(aw) - int'(ar);
         cmp_flags(exp_flags(), flags);
      end
      cmp_word(66'h0, 66'(wq.size()));
      $display("test cascade done");
   endtask

   // fill past capacity, mix at random, then drain past empty
   task automatic run_cfg(input logic h, input logic o, input logic n);
      int i;
      cfg = '{half: h, ecc_en: 1'b1, out_reg: o, rd_narrow: n, casc_in: 1'b0, casc_out: 1'b0};
      cap = h ? 256 : 512;
      afull_lvl = 10'(1 + {$random(seed)} % cap);
      aempty_lvl = 10'({$random(seed)} % cap);
      for (i = 0; i <= cap; i++) step(1'b1, {$random(seed), $random(seed)}, 1'b0, 1'b1);
      for (i = 0; i < 400; i++) begin
         step(1'($random(seed)), {$random(seed), $random(seed)}, 1'($random(seed)),
              1'($random(seed)));
      end
      for (i = 0; i < 2 * cap + 3; i++) step(1'b0, 64'h0, 1'b1, 1'b1);
      repeat (3) step(1'b0, 64'h0, 1'b0, 1'b0);
      cmp_word(66'h0, 66'(bq.size()));
      $display("test cfg %0d%0d%0d done", h, o, n);
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      cmp_flags(4'b0101, flags);
      $display("test reset done");
      step(1'b0, 64'h0, 1'b0, 1'b0);
      reset_test();
      codec_test();
      run_cfg(1'b0, 1'b0, 1'b0);
      run_cfg(1'b1, 1'b1, 1'b0);
      run_cfg(1'b0, 1'b0, 1'b1);
      run_cfg(1'b1, 1'b1, 1'b1);
      casc_test();
      tally_and_finish();
   end
endmodule // test_ecc_block_ram_fifo
